// *** core/ssr_pkg.sv ***
// package: register map, reset values, field positions and carriers of the sync source registers
//
// What this block does
// - override set: take path from choice bit
// - override clear and not both present: take path from detected status
// - choice 0 analog, 1 digital
// - honor choice on override or both present
// - hsync source from override or both hsync and green present, else detected
// - hsync choice 0 pin, 1 green
// - vsync source from override, else detected
// - vsync choice 0 raw, 1 separator
// - coast from pin or from vsync
// - active-low full chip sleep, resets awake
// - separator counts to threshold before toggling
// - scan enable bit
// - coast polarity self or configured
// - hsync polarity self or configured
// - status reports hsync and coast polarity
// - vsync polarity status uses inverted coding
// - slicer level bits, reset 10111
// - coast starts lead lines before vsync
// - coast holds trail lines after vsync
// - detected path reads 0 analog, 1 digital
// - detected hsync reads 0 pin, 1 green
package ssr_pkg;
   // ==========================================================
   // register offsets
   localparam logic [7:0] SSR_OFS_SELECT = 8'h12;
   localparam logic [7:0] SSR_OFS_SEP_LIMIT = 8'h13;
   localparam logic [7:0] SSR_OFS_POL_CTRL = 8'h14;
   localparam logic [7:0] SSR_OFS_POL_STAT = 8'h15;
   localparam logic [7:0] SSR_OFS_SLICER = 8'h16;
   localparam logic [7:0] SSR_OFS_LEAD = 8'h17;
   localparam logic [7:0] SSR_OFS_TRAIL = 8'h18;
   localparam logic [7:0] SSR_OFS_TEST_A = 8'h19;
   localparam logic [7:0] SSR_OFS_TEST_B = 8'h1a;
   // ==========================================================
   // values after reset
   localparam logic [7:0] SSR_RST_SELECT = 8'h01;
   localparam logic [7:0] SSR_RST_SEP_LIMIT = 8'h20;
   localparam logic [7:0] SSR_RST_POL_CTRL = 8'h00;
   localparam logic [7:0] SSR_RST_SLICER = 8'hbc;
   localparam logic [7:0] SSR_RST_LEAD = 8'h00;
   localparam logic [7:0] SSR_RST_TRAIL = 8'h00;
   localparam logic [7:0] SSR_RST_TEST_A = 8'h00;
   localparam logic [7:0] SSR_RST_TEST_B = 8'hff;
   // writable bits of the slicer register (bits 1:0 read zero)
   localparam logic [7:0] SSR_MSK_SLICER = 8'hfc;
   // ==========================================================
   // field positions, select register
   localparam int SSR_B_PATH_OVR = 7;
   localparam int SSR_B_PATH_SEL = 6;
   localparam int SSR_B_HS_OVR = 5;
   localparam int SSR_B_HS_SEL = 4;
   localparam int SSR_B_VS_OVR = 3;
   localparam int SSR_B_VS_SEL = 2;
   localparam int SSR_B_COAST_SRC = 1;
   localparam int SSR_B_SLEEP_N = 0;
   // field positions, polarity control and status
   localparam int SSR_B_SCAN = 2;
   localparam int SSR_B_COAST_POL_OVR = 1;
   localparam int SSR_B_HS_POL_OVR = 0;
   localparam int SSR_B_ST_HS_POL = 7;
   localparam int SSR_B_ST_VS_POL = 6;
   localparam int SSR_B_ST_COAST_POL = 5;
   // slicer level field
   localparam int SSR_B_SLICER_LO = 3;
   // ==========================================================
   // widths and counters
   localparam int SSR_BAL_W = 16;
   localparam int SSR_LINE_W = 11;
   localparam logic [SSR_LINE_W-1:0] SSR_LINE_MAX = 11'h7ff;
   // polarity channels: hsync, vsync pin, coast pin
   localparam int SSR_CH_HS = 0;
   localparam int SSR_CH_VS = 1;
   localparam int SSR_CH_COAST = 2;
   // pin bit order in the synchroniser
   localparam int SSR_P_HS = 0;
   localparam int SSR_P_SOG = 1;
   localparam int SSR_P_VS = 2;
   localparam int SSR_P_COAST = 3;
   // ==========================================================
   // carriers
   typedef struct packed {
      logic analog_hs_det;         // hsync present on analog side
      logic analog_sog_det;        // sync present on green
      logic analog_vs_det;         // vsync present on analog side
      logic digital_clk_det;       // clock present on digital side
      logic detected_input_path;   // 0 analog, 1 digital
      logic detected_hsync_source; // 0 hsync pin, 1 sync on green
      logic detected_vsync_source; // 0 raw, 1 separator
   } ssr_status_s;

   typedef struct packed {
      logic input_path_digital;   // active path, 1 = digital
      logic hsync_from_green;     // hsync source, 1 = green
      logic vsync_from_separator; // vsync source, 1 = separator
      logic coast_from_vsync;     // coast source, 1 = vsync
      logic chip_sleep_n;         // 0 = whole chip powered down
      logic scan_en;              // scan mode enable
      logic hs_pol_high;          // effective hsync polarity
      logic coast_pol_high;       // effective coast polarity
      logic [4:0] slicer_level;   // sync-on-green slicer threshold
   } ssr_route_s;
endpackage : ssr_pkg

// *** core/ssr_regs.sv ***
// module: sync source selection registers with polarity, separator and coast timing
module ssr_regs (
   // clock and reset
   input wire logic clk,
   input wire logic sys_rst,
   // register access from the two-wire control engine
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   output logic [7:0] reg_rdata,
   // detection status and pll config, same clock
   input wire ssr_pkg::ssr_status_s det,
   input wire logic pll_hs_pol_cfg,
   input wire logic pll_coast_pol_cfg,
   // raw pins from outside the clock domain
   input wire logic hs_pin,
   input wire logic sog_pin,
   input wire logic vs_pin,
   input wire logic coast_pin,
   // routing and timing results
   output ssr_pkg::ssr_route_s route,
   output logic sep_vsync,
   output logic coast_out
);
   // ==========================================================
   // register file
   logic [7:0] sel_q, sel_d;       // source select and sleep
   logic [7:0] lim_q, lim_d;       // separator count limit
   logic [7:0] polc_q, polc_d;     // polarity override and scan
   logic [7:0] slc_q, slc_d;       // slicer level
   logic [7:0] lead_q, lead_d;     // coast lines before vsync
   logic [7:0] trail_q, trail_d;   // coast lines after vsync
   logic [7:0] ta_q, ta_d;         // factory test a
   logic [7:0] tb_q, tb_d;         // factory test b
   logic [7:0] rdata_d;            // read mux
   logic [7:0] stat_c;             // polarity status view

   // write decode; the status register has no write branch
   always_comb begin
      sel_d = sel_q;
      lim_d = lim_q;
      polc_d = polc_q;
      slc_d = slc_q;
      lead_d = lead_q;
      trail_d = trail_q;
      ta_d = ta_q;
      tb_d = tb_q;
      if (reg_wr) begin
         unique case (reg_addr)
            ssr_pkg::SSR_OFS_SELECT: sel_d = reg_wdata;
            ssr_pkg::SSR_OFS_SEP_LIMIT: lim_d = reg_wdata;
            ssr_pkg::SSR_OFS_POL_CTRL: polc_d = reg_wdata;
            ssr_pkg::SSR_OFS_SLICER: slc_d = reg_wdata & ssr_pkg::SSR_MSK_SLICER;
            ssr_pkg::SSR_OFS_LEAD: lead_d = reg_wdata;
            ssr_pkg::SSR_OFS_TRAIL: trail_d = reg_wdata;
            ssr_pkg::SSR_OFS_TEST_A: ta_d = reg_wdata;
            ssr_pkg::SSR_OFS_TEST_B: tb_d = reg_wdata;
            default: ; // status and unmapped writes dropped
         endcase
      end
   end

   // read mux, unmapped reads return zero
   always_comb begin
      rdata_d = reg_rdata;
      if (reg_rd) begin
         unique case (reg_addr)
            ssr_pkg::SSR_OFS_SELECT: rdata_d = sel_q;
            ssr_pkg::SSR_OFS_SEP_LIMIT: rdata_d = lim_q;
            ssr_pkg::SSR_OFS_POL_CTRL: rdata_d = polc_q;
            ssr_pkg::SSR_OFS_POL_STAT: rdata_d = stat_c;
            ssr_pkg::SSR_OFS_SLICER: rdata_d = slc_q;
            ssr_pkg::SSR_OFS_LEAD: rdata_d = lead_q;
            ssr_pkg::SSR_OFS_TRAIL: rdata_d = trail_q;
            ssr_pkg::SSR_OFS_TEST_A: rdata_d = ta_q;
            ssr_pkg::SSR_OFS_TEST_B: rdata_d = tb_q;
            default: rdata_d = 8'h00;
         endcase
      end
   end

   // register storage
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         sel_q <= ssr_pkg::SSR_RST_SELECT; // awake after reset
         lim_q <= ssr_pkg::SSR_RST_SEP_LIMIT;
         polc_q <= ssr_pkg::SSR_RST_POL_CTRL;
         slc_q <= ssr_pkg::SSR_RST_SLICER;
         lead_q <= ssr_pkg::SSR_RST_LEAD;
         trail_q <= ssr_pkg::SSR_RST_TRAIL;
         ta_q <= ssr_pkg::SSR_RST_TEST_A;
         tb_q <= ssr_pkg::SSR_RST_TEST_B;
         reg_rdata <= 8'h00;
      end else begin
         sel_q <= sel_d;
         lim_q <= lim_d;
         polc_q <= polc_d;
         slc_q <= slc_d;
         lead_q <= lead_d;
         trail_q <= trail_d;
         ta_q <= ta_d;
         tb_q <= tb_d;
         reg_rdata <= rdata_d;
      end
   end

   // ==========================================================
   // pin synchronisers: second stage is the only reader of the first
   logic [3:0] meta_q, pin_q, prev_q;
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         meta_q <= 4'h0;
         pin_q <= 4'h0;
      end else begin
         meta_q <= {coast_pin, vs_pin, sog_pin, hs_pin};
         pin_q <= meta_q;
      end
   end

   // ==========================================================
   // source routing
   ssr_pkg::ssr_route_s route_d;
   logic [2:0] pol_q, pol_d; // detected polarity per channel, 1 = active high
   logic both_path_c, both_hs_c;
   always_comb begin
      both_path_c = (det.analog_hs_det | det.analog_sog_det) & det.digital_clk_det;
      both_hs_c = det.analog_hs_det & det.analog_sog_det;
      // detected codes: path 0 analog / 1 digital, hsync 0 pin / 1 green
      route_d.input_path_digital = (sel_q[ssr_pkg::SSR_B_PATH_OVR] | both_path_c) ?
         sel_q[ssr_pkg::SSR_B_PATH_SEL] : det.detected_input_path;
      route_d.hsync_from_green = (sel_q[ssr_pkg::SSR_B_HS_OVR] | both_hs_c) ?
         sel_q[ssr_pkg::SSR_B_HS_SEL] : det.detected_hsync_source;
      route_d.vsync_from_separator = sel_q[ssr_pkg::SSR_B_VS_OVR] ?
         sel_q[ssr_pkg::SSR_B_VS_SEL] : det.detected_vsync_source;
      route_d.coast_from_vsync = sel_q[ssr_pkg::SSR_B_COAST_SRC];
      route_d.chip_sleep_n = sel_q[ssr_pkg::SSR_B_SLEEP_N];
      route_d.scan_en = polc_q[ssr_pkg::SSR_B_SCAN];
      route_d.hs_pol_high = polc_q[ssr_pkg::SSR_B_HS_POL_OVR] ?
         pll_hs_pol_cfg : pol_q[ssr_pkg::SSR_CH_HS];
      route_d.coast_pol_high = polc_q[ssr_pkg::SSR_B_COAST_POL_OVR] ?
         pll_coast_pol_cfg : pol_q[ssr_pkg::SSR_CH_COAST];
      route_d.slicer_level = slc_q[7:ssr_pkg::SSR_B_SLICER_LO];
   end

   // ==========================================================
   // polarity detection: a pulse shorter than its gap is the active level
   logic signed [ssr_pkg::SSR_BAL_W-1:0] bal_q [3], bal_d [3];
   logic [2:0] raw_c, rise_c;
   logic hs_raw_c, hs_act_c, vs_act_c, coast_pin_act_c;
   always_comb begin
      hs_raw_c = route.hsync_from_green ? pin_q[ssr_pkg::SSR_P_SOG] : pin_q[ssr_pkg::SSR_P_HS];
      raw_c = {pin_q[ssr_pkg::SSR_P_COAST], pin_q[ssr_pkg::SSR_P_VS], hs_raw_c};
      pol_d = pol_q;
      for (int i = 0; i < 3; i++) begin
         rise_c[i] = raw_c[i] & ~prev_q[i];
         bal_d[i] = bal_q[i];
         if (rise_c[i]) begin
            // high time minus low time over the last period
            pol_d[i] = bal_q[i] < 0;
            bal_d[i] = '0;
         end else if (raw_c[i] && bal_q[i] != {1'b0, {(ssr_pkg::SSR_BAL_W-1){1'b1}}}) begin
            // step is a full-width literal: a one-bit signed one would read as minus one
            bal_d[i] = bal_q[i] + 16'sh0001;
         end else if (!raw_c[i] && bal_q[i] != {1'b1, {(ssr_pkg::SSR_BAL_W-1){1'b0}}}) begin
            bal_d[i] = bal_q[i] - 16'sh0001;
         end
      end
      hs_act_c = hs_raw_c ~^ route.hs_pol_high;
      coast_pin_act_c = pin_q[ssr_pkg::SSR_P_COAST] ~^ route.coast_pol_high;
      stat_c = 8'h00;
      stat_c[ssr_pkg::SSR_B_ST_HS_POL] = pol_q[ssr_pkg::SSR_CH_HS];
      stat_c[ssr_pkg::SSR_B_ST_COAST_POL] = pol_q[ssr_pkg::SSR_CH_COAST];
      // raw vsync passes unchanged; separator output is always active high
      stat_c[ssr_pkg::SSR_B_ST_VS_POL] = ~route.vsync_from_separator &
         ~pol_q[ssr_pkg::SSR_CH_VS];
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         pol_q <= 3'h7;
         prev_q <= 4'h0;
         for (int i = 0; i < 3; i++) begin
            bal_q[i] <= '0;
         end
      end else begin
         pol_q <= pol_d;
         prev_q <= {1'b0, raw_c};
         for (int i = 0; i < 3; i++) begin
            bal_q[i] <= bal_d[i];
         end
      end
   end

   // ==========================================================
   // sync separator: output follows hsync only after it held limit clocks
   logic [7:0] scnt_q, scnt_d;
   logic sep_d, hs_prev_q, vs_prev_q;
   logic [8:0] snext_c;
   always_comb begin
      snext_c = {1'b0, scnt_q} + 9'h001;
      scnt_d = 8'h00;
      sep_d = sep_vsync;
      if (hs_act_c != sep_vsync) begin
         if (snext_c >= {1'b0, lim_q}) begin
            sep_d = hs_act_c;
         end else begin
            scnt_d = snext_c[7:0];
         end
      end
      if (!route.chip_sleep_n) begin
         sep_d = 1'b0;
         scnt_d = 8'h00;
      end
   end

   // ==========================================================
   // coast window: lead lines before and trail lines after vsync
   logic [ssr_pkg::SSR_LINE_W-1:0] line_q, line_d, frame_q, frame_d;
   logic [7:0] tcnt_q, tcnt_d;
   logic coast_d, hs_rise_c, vs_rise_c, lead_win_c, coast_int_c;
   logic [ssr_pkg::SSR_LINE_W:0] reach_c;
   always_comb begin
      vs_act_c = route.vsync_from_separator ? sep_vsync :
         (pin_q[ssr_pkg::SSR_P_VS] ~^ pol_q[ssr_pkg::SSR_CH_VS]);
      hs_rise_c = hs_act_c & ~hs_prev_q;
      vs_rise_c = vs_act_c & ~vs_prev_q;
      reach_c = {1'b0, line_q} + {4'h0, lead_q};
      // lead window needs one whole frame measured first
      lead_win_c = (lead_q != 8'h00) && (frame_q != '0) && (reach_c >= {1'b0, frame_q});
      coast_int_c = vs_act_c | lead_win_c | (tcnt_q != 8'h00);
      line_d = line_q;
      frame_d = frame_q;
      tcnt_d = tcnt_q;
      if (vs_rise_c) begin
         frame_d = line_q;
         line_d = '0;
      end else if (hs_rise_c && line_q != ssr_pkg::SSR_LINE_MAX) begin
         line_d = line_q + 1'b1;
      end
      if (vs_act_c) begin
         tcnt_d = trail_q; // trail count starts when vsync ends
      end else if (hs_rise_c && tcnt_q != 8'h00) begin
         tcnt_d = tcnt_q - 8'h01;
      end
      coast_d = route.coast_from_vsync ? coast_int_c : coast_pin_act_c;
      if (!route.chip_sleep_n) begin
         line_d = '0;
         frame_d = '0;
         tcnt_d = 8'h00;
         coast_d = 1'b0;
      end
   end

   // timing and routing registers
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         route <= '{default: 1'b0, chip_sleep_n: 1'b1, hs_pol_high: 1'b1,
                    coast_pol_high: 1'b1, slicer_level: 5'h17};
         scnt_q <= 8'h00;
         sep_vsync <= 1'b0;
         hs_prev_q <= 1'b0;
         vs_prev_q <= 1'b0;
         line_q <= '0;
         frame_q <= '0;
         tcnt_q <= 8'h00;
         coast_out <= 1'b0;
      end else begin
         route <= route_d;
         scnt_q <= scnt_d;
         sep_vsync <= sep_d;
         hs_prev_q <= hs_act_c;
         vs_prev_q <= vs_act_c;
         line_q <= line_d;
         frame_q <= frame_d;
         tcnt_q <= tcnt_d;
         coast_out <= coast_d;
      end
   end

   // ==========================================================
   // assertions
   default clocking cb @(posedge clk); endclocking
   default disable iff (sys_rst);

   path_override_a: assert property ($past(sel_q[7]) |->
      route.input_path_digital == $past(sel_q[6]))
      else $error("override path not taken from choice bit");
   path_auto_a: assert property (!$past(sel_q[7]) && !$past(both_path_c) |->
      route.input_path_digital == $past(det.detected_input_path))
      else $error("auto path not taken from detected status");
   path_both_a: assert property ($past(both_path_c) |->
      route.input_path_digital == $past(sel_q[6]))
      else $error("choice not honored with both paths present");
   hs_source_a: assert property ($past(sel_q[5]) |->
      route.hsync_from_green == $past(sel_q[4]))
      else $error("hsync override not applied");
   vs_source_a: assert property (!$past(sel_q[3]) |->
      route.vsync_from_separator == $past(det.detected_vsync_source))
      else $error("vsync not following detected source");
   sleep_write_a: assert property (reg_wr && reg_addr == 8'h12 && !reg_wdata[0] |->
      ##2 !route.chip_sleep_n ##1 !coast_out)
      else $error("sleep write did not power down");
   sep_limit_a: assert property ($changed(sep_vsync) && $past(route.chip_sleep_n) |->
      ({1'b0, $past(scnt_q)} + 9'h001) >= {1'b0, $past(lim_q)})
      else $error("separator toggled before limit");
   pol_status_a: assert property (reg_rd && reg_addr == 8'h15 |=>
      reg_rdata[7] == $past(pol_q[0]) && reg_rdata[5] == $past(pol_q[2]) && reg_rdata[4:0] == 5'h00)
      else $error("polarity status read wrong");
   stat_write_a: assert property (reg_wr && reg_addr == 8'h15 |=>
      $stable(sel_q) && $stable(polc_q) && $stable(slc_q))
      else $error("status write changed a register");
   slicer_mask_a: assert property (reg_wr && reg_addr == 8'h16 |=>
      slc_q == ($past(reg_wdata) & 8'hfc))
      else $error("slicer write not masked");
   trail_load_a: assert property ($fell(vs_act_c) && route.chip_sleep_n |->
      tcnt_q == trail_q)
      else $error("trail count not loaded at vsync end");

   sleep_c: cover property (reg_wr && reg_addr == 8'h12 && !reg_wdata[0]);
   override_c: cover property (sel_q[7] && route.input_path_digital);
   coast_c: cover property (route.coast_from_vsync && lead_win_c && !vs_act_c);
   sep_c: cover property ($rose(sep_vsync));
endmodule : ssr_regs

// *** sim/ssr_host.sv ***
// host controller model driving the register strobe port of the sync source registers
module ssr_host (
   // clock
   input wire logic clk,
   // register port toward the block
   output logic reg_wr,
   output logic reg_rd,
   output logic [7:0] reg_addr,
   output logic [7:0] reg_wdata,
   input wire logic [7:0] reg_rdata
);
   timeunit 1ns;
   timeprecision 1ps;
   // ==========================================================
   // idle port at time zero
   initial begin
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      reg_addr = 8'h00;
      reg_wdata = 8'h00;
   end
   // one write; data is scrambled once released so stale values never look valid
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge clk);
      reg_wr = 1'b1;
      reg_addr = a;
      reg_wdata = d;
      @(negedge clk);
      reg_wr = 1'b0;
      reg_wdata = ~d;
   endtask : wr
   // one read; data is taken one cycle after the strobe edge
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(negedge clk);
      reg_rd = 1'b1;
      reg_addr = a;
      @(negedge clk);
      reg_rd = 1'b0;
      d = reg_rdata;
   endtask : rd
   // settings the block needs before normal use; the first test register stays zero
   task automatic setup();
      wr(ssr_pkg::SSR_OFS_POL_CTRL, 8'h10);
      wr(ssr_pkg::SSR_OFS_SLICER, 8'hb8);
      wr(ssr_pkg::SSR_OFS_TEST_B, 8'h41);
   endtask : setup
endmodule : ssr_host

// *** sim/sync_source_select_regs_test.sv ***
// testbench of the sync source registers: register map, routing, coast and separator
module sync_source_select_regs_test;
   timeunit 1ns;
   timeprecision 1ps;
   // ==========================================================
   // signals
   logic clk, sys_rst, reg_wr, reg_rd, hs_pin, sog_pin, vs_pin, coast_pin, hs_cfg, coast_cfg;
   logic sep_vsync, coast_out, low_ok;
   logic [7:0] reg_addr, reg_wdata, reg_rdata, v, s, r12, r14, r16;
   ssr_pkg::ssr_status_s det;
   ssr_pkg::ssr_route_s route, e, m;
   int num_errors, checks, k;
   logic [7:0] rst_val [9] = '{8'h01, 8'h20, 8'h00, 8'h00, 8'hbc, 8'h00, 8'h00, 8'h00, 8'hff};
   logic [7:0] corner [4] = '{8'hc1, 8'h41, 8'hff, 8'h3e};
   logic [7:0] plain [3] = '{8'h13, 8'h17, 8'h18};
   // ==========================================================
   // block and host
   ssr_regs DUT (.clk(clk), .sys_rst(sys_rst), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .det(det),
      .pll_hs_pol_cfg(hs_cfg), .pll_coast_pol_cfg(coast_cfg), .hs_pin(hs_pin),
      .sog_pin(sog_pin), .vs_pin(vs_pin), .coast_pin(coast_pin), .route(route),
      .sep_vsync(sep_vsync), .coast_out(coast_out));
   ssr_host host (.clk(clk), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_rdata(reg_rdata));
   // 50 MHz clock
   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end
   // ==========================================================
   // helpers
   task automatic cmp(input string n, input logic [15:0] x, input logic [15:0] g);
      checks++;
      if (g !== x) begin
         num_errors++;
         $display("MISMATCH %s expected %h seen %h", n, x, g);
      end
   endtask : cmp
   task automatic finish_test();
      $display("checks %0d num_errors %0d", checks, num_errors);
      if (num_errors == 0 && checks > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask : finish_test
   // bounded wait on separator (sel 1) or coast output (sel 0)
   task automatic wait_lvl(input string n, input bit sel, input logic val, input int lim);
      for (k = 0; k < lim; k++) begin
         @(negedge clk);
         if ((sel ? sep_vsync : coast_out) === val) break;
      end
      cmp(n, 16'(val), 16'(sel ? sep_vsync : coast_out));
      if (k == lim) finish_test();
   endtask : wait_lvl
   // routing expected from register values and detection status
   function automatic ssr_pkg::ssr_route_s exp_route(logic [7:0] a, logic [7:0] c,
         logic [7:0] g, ssr_pkg::ssr_status_s d);
      ssr_pkg::ssr_route_s r;
      r.input_path_digital = (a[7] | ((d.analog_hs_det | d.analog_sog_det) & d.digital_clk_det))
         ? a[6] : d.detected_input_path;
      r.hsync_from_green = (a[5] | (d.analog_hs_det & d.analog_sog_det)) ? a[4]
         : d.detected_hsync_source;
      r.vsync_from_separator = a[3] ? a[2] : d.detected_vsync_source;
      r.coast_from_vsync = a[1];
      r.chip_sleep_n = a[0];
      r.scan_en = c[2];
      r.hs_pol_high = hs_cfg;
      r.coast_pol_high = coast_cfg;
      r.slicer_level = g[7:3];
      return r;
   endfunction : exp_route
   // watchdog: a hang counts as a mismatch
   initial begin
      #2ms;
      num_errors++;
      finish_test();
   end
   // ==========================================================
   // main sequence
   initial begin
      void'($urandom(9932));
      {sys_rst, hs_pin, sog_pin, vs_pin, coast_pin, hs_cfg, coast_cfg} = 7'h40;
      det = '0;
      num_errors = 0;
      checks = 0;
      repeat (16) @(negedge clk);
      sys_rst = 1'b0;
      // reset values of every mapped register except the status
      for (int a = 0; a < 9; a++) begin
         if (a != 3) begin
            host.rd(8'h12 + 8'(a), v);
            cmp("reset value", 16'(rst_val[a]), 16'(v));
         end
      end
      host.setup();
      // routing under random and corner selections
      for (int i = 0; i < 40; i++) begin
         r12 = (i < 4) ? corner[i] : 8'($urandom());
         r14 = {3'h0, 2'b10, 3'($urandom())};
         r16 = {5'($urandom()), 3'h0};
         det = 7'($urandom());
         hs_cfg = 1'($urandom());
         coast_cfg = 1'($urandom());
         host.wr(ssr_pkg::SSR_OFS_SELECT, r12);
         host.wr(ssr_pkg::SSR_OFS_POL_CTRL, r14);
         host.wr(ssr_pkg::SSR_OFS_SLICER, r16);
         repeat (3) @(negedge clk);
         e = exp_route(r12, r14, r16, det);
         m = '1;
         m.hs_pol_high = r14[0];
         m.coast_pol_high = r14[1];
         cmp("route", 16'(e & m), 16'(route & m));
         host.rd(ssr_pkg::SSR_OFS_SELECT, v);
         cmp("select readback", 16'(r12), 16'(v));
         r16 = 8'($urandom());
         host.wr(plain[i % 3], r16);
         host.rd(plain[i % 3], v);
         cmp("count readback", 16'(r16), 16'(v));
      end
      // refused writes: slicer low bits, status register, unmapped place
      host.wr(ssr_pkg::SSR_OFS_SLICER, 8'hff);
      host.rd(ssr_pkg::SSR_OFS_SLICER, v);
      cmp("slicer mask", 16'h00fc, 16'(v));
      host.wr(ssr_pkg::SSR_OFS_SLICER, 8'hb8);
      host.rd(ssr_pkg::SSR_OFS_POL_STAT, s);
      // pins idle since reset: every channel still active high, vsync bit reads 0
      cmp("status value", 16'h00a0, 16'(s));
      host.wr(ssr_pkg::SSR_OFS_POL_STAT, ~s);
      host.rd(ssr_pkg::SSR_OFS_POL_STAT, v);
      cmp("status after write", 16'(s & 8'he0), 16'(v));
      host.wr(8'h1b, 8'h10);
      host.rd(8'h1b, v);
      cmp("unmapped read", 16'h0000, 16'(v));
      // coast from pin, active high, then held off while asleep
      coast_cfg = 1'b1;
      host.wr(ssr_pkg::SSR_OFS_POL_CTRL, 8'h12);
      host.wr(ssr_pkg::SSR_OFS_SELECT, 8'h01);
      coast_pin = 1'b1;
      wait_lvl("coast from pin high", 1'b0, 1'b1, 8);
      coast_pin = 1'b0;
      wait_lvl("coast from pin low", 1'b0, 1'b0, 8);
      host.wr(ssr_pkg::SSR_OFS_SELECT, 8'h00);
      coast_pin = 1'b1;
      repeat (10) @(negedge clk);
      cmp("coast asleep", 16'h0000, 16'(coast_out));
      coast_pin = 1'b0;
      // separator: short pulses stay below the limit, a long one crosses it
      hs_cfg = 1'b1;
      host.wr(ssr_pkg::SSR_OFS_POL_CTRL, 8'h11);
      host.wr(ssr_pkg::SSR_OFS_SELECT, 8'h21);
      host.wr(ssr_pkg::SSR_OFS_SEP_LIMIT, 8'h10);
      repeat (4) @(negedge clk);
      low_ok = 1'b1;
      for (int p = 0; p < 36; p++) begin
         hs_pin = (p % 12) < 6;
         @(negedge clk);
         if (sep_vsync !== 1'b0) low_ok = 1'b0;
      end
      cmp("separator short pulses", 16'h0001, 16'(low_ok));
      hs_pin = 1'b1;
      wait_lvl("separator rise", 1'b1, 1'b1, 30);
      cmp("separator delay", 16'h0001, 16'(k >= 15 && k <= 22));
      hs_pin = 1'b0;
      wait_lvl("separator fall", 1'b1, 1'b0, 30);
      // coast from raw vsync: high with vsync, then held for two hsync rises
      host.wr(ssr_pkg::SSR_OFS_LEAD, 8'h00);
      host.wr(ssr_pkg::SSR_OFS_TRAIL, 8'h02);
      host.wr(ssr_pkg::SSR_OFS_SELECT, 8'h2b);
      vs_pin = 1'b1;
      wait_lvl("coast from vsync", 1'b0, 1'b1, 8);
      vs_pin = 1'b0;
      repeat (8) @(negedge clk);
      for (int p = 0; p < 2; p++) begin
         cmp("coast trail hold", 16'h0001, 16'(coast_out));
         hs_pin = 1'b1;
         repeat (3) @(negedge clk);
         hs_pin = 1'b0;
         repeat (3) @(negedge clk);
      end
      cmp("coast trail end", 16'h0000, 16'(coast_out));
      finish_test();
   end
endmodule : sync_source_select_regs_test
